// *** dar_pkg.sv ***
// constants for the diagnostic result byte bank
package dar_pkg;

  // serial address of the diagnostic page, 7-bit form
  localparam logic [6:0] DAR_SERIAL_ADDR = 7'h51;

  localparam logic [7:0] DAR_OFS_TEMP_HI = 8'h60;
  localparam logic [7:0] DAR_OFS_TEMP_LO = 8'h61;
  localparam logic [7:0] DAR_OFS_VIN_HI = 8'h62;
  localparam logic [7:0] DAR_OFS_VIN_LO = 8'h63;
  localparam logic [7:0] DAR_OFS_BIAS_HI = 8'h64;
  localparam logic [7:0] DAR_OFS_BIAS_LO = 8'h65;
  localparam logic [7:0] DAR_OFS_TXOP_HI = 8'h66;
  localparam logic [7:0] DAR_OFS_TXOP_LO = 8'h67;

  localparam logic [7:0] DAR_RST_RESULT = 8'h00;
  localparam logic [7:0] DAR_LOW_BYTE_VAL = 8'h00;
  localparam logic [7:0] DAR_UNMAPPED_VAL = 8'h00;

  // conversion channel codes
  localparam logic [1:0] DAR_CH_TEMP = 2'h0;
  localparam logic [1:0] DAR_CH_VIN = 2'h1;
  localparam logic [1:0] DAR_CH_BIAS = 2'h2;
  localparam logic [1:0] DAR_CH_TXOP = 2'h3;

endpackage

// *** dar_result_regs.sv ***
// diagnostic result byte bank with host read port
`timescale 1ns/1ps
`default_nettype none
module dar_result_regs
  import dar_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic conv_valid_i,
  input wire logic [1:0] conv_chan_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [6:0] slave_addr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o,
  output logic por_busy_o,
  output logic [DATA_W-1:0] cmp_temp_o,
  output logic [DATA_W-1:0] cmp_vin_o,
  output logic [DATA_W-1:0] cmp_bias_o,
  output logic [DATA_W-1:0] cmp_txop_o
);

  ////////////////////////////////////////////////////////////////////////
  // storage

  logic [DATA_W-1:0] temp_ff;
  logic [DATA_W-1:0] vin_ff;
  logic [DATA_W-1:0] bias_ff;
  logic [DATA_W-1:0] txop_ff;
  logic [3:0] seen_ff;
  logic por_ff;
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic conv_fire;
  logic bus_hit;
  logic rd_fire;
  logic unused_wdata;

  assign conv_fire = ce_i && conv_valid_i;
  assign bus_hit = req_i && (slave_addr_i == DAR_SERIAL_ADDR);
  assign rd_fire = ce_i && bus_hit && !we_i;
  // write data has no destination: every byte here is read-only
  assign unused_wdata = ^wdata_i;

  ////////////////////////////////////////////////////////////////////////
  // conversion capture

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      temp_ff <= DATA_W'(DAR_RST_RESULT);
    end else if (conv_fire && conv_chan_i == DAR_CH_TEMP) begin
      temp_ff <= conv_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vin_ff <= DATA_W'(DAR_RST_RESULT);
    end else if (conv_fire && conv_chan_i == DAR_CH_VIN) begin
      vin_ff <= conv_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bias_ff <= DATA_W'(DAR_RST_RESULT);
    end else if (conv_fire && conv_chan_i == DAR_CH_BIAS) begin
      bias_ff <= conv_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      txop_ff <= DATA_W'(DAR_RST_RESULT);
    end else if (conv_fire && conv_chan_i == DAR_CH_TXOP) begin
      txop_ff <= conv_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on status

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seen_ff <= 4'h0;
    end else if (conv_fire) begin
      seen_ff[conv_chan_i] <= 1'b1;
    end
  end

  // status lags the last capture by one cycle so data is settled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_ff <= 1'b1;
    end else if (ce_i) begin
      por_ff <= !(&seen_ff);
    end
  end

  assign por_busy_o = por_ff;

  ////////////////////////////////////////////////////////////////////////
  // threshold feed

  assign cmp_temp_o = temp_ff;
  assign cmp_vin_o = vin_ff;
  assign cmp_bias_o = bias_ff;
  assign cmp_txop_o = txop_ff;

  ////////////////////////////////////////////////////////////////////////
  // host read port

  always_comb begin
    nxt_rdata = DAR_UNMAPPED_VAL;
    if (addr_i == DAR_OFS_TEMP_HI) begin
      nxt_rdata = 8'(temp_ff);
    end else if (addr_i == DAR_OFS_TEMP_LO) begin
      nxt_rdata = DAR_LOW_BYTE_VAL;
    end else if (addr_i == DAR_OFS_VIN_HI) begin
      nxt_rdata = 8'(vin_ff);
    end else if (addr_i == DAR_OFS_VIN_LO) begin
      nxt_rdata = DAR_LOW_BYTE_VAL;
    end else if (addr_i == DAR_OFS_BIAS_HI) begin
      nxt_rdata = 8'(bias_ff);
    end else if (addr_i == DAR_OFS_BIAS_LO) begin
      nxt_rdata = DAR_LOW_BYTE_VAL;
    end else if (addr_i == DAR_OFS_TXOP_HI) begin
      nxt_rdata = 8'(txop_ff);
    end else if (addr_i == DAR_OFS_TXOP_LO) begin
      nxt_rdata = DAR_LOW_BYTE_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= bus_hit;
    end
  end

  // read data holds until the next read so a slow host can sample it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= DAR_RST_RESULT;
    end else if (rd_fire) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign ack_o = ack_ff;
  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dar_cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_reset_clears: assert property (
    disable iff (1'b0)
    srst_i |=> temp_ff == DATA_W'(DAR_RST_RESULT) && vin_ff == temp_ff &&
    bias_ff == temp_ff && txop_ff == temp_ff && !ack_o &&
    rdata_o == DAR_RST_RESULT && por_busy_o
  ) else $error("reset left state behind");

  a_temp_capture: assert property (
    ce_i && conv_valid_i && conv_chan_i == DAR_CH_TEMP
    |=> temp_ff == $past(conv_data_i)
  ) else $error("temperature not captured");

  a_vin_hold: assert property (
    !(ce_i && conv_valid_i && conv_chan_i == DAR_CH_VIN)
    |=> $stable(vin_ff)
  ) else $error("supply byte changed without conversion");

  a_temp_read: assert property (
    ce_i && req_i && !we_i && slave_addr_i == DAR_SERIAL_ADDR &&
    addr_i == DAR_OFS_TEMP_HI && !conv_valid_i
    |=> ack_o && rdata_o == 8'($past(temp_ff))
  ) else $error("temperature read wrong");

  a_low_zero: assert property (
    ce_i && req_i && !we_i && slave_addr_i == DAR_SERIAL_ADDR &&
    addr_i[7:3] == 5'h0C && addr_i[0]
    |=> ack_o && rdata_o == 8'h00
  ) else $error("low byte not zero");

  a_write_ignored: assert property (
    req_i && we_i && !conv_valid_i
    |=> $stable(temp_ff) && $stable(bias_ff) && $stable(txop_ff)
  ) else $error("write altered a result");

  a_por_ready: assert property (
    ce_i && (&seen_ff) |=> !por_busy_o
  ) else $error("status still busy");

  a_por_busy: assert property (
    !(&seen_ff) && ce_i |=> por_busy_o
  ) else $error("status ready too early");

  a_txop_cmp: assert property (
    ce_i && conv_valid_i && conv_chan_i == DAR_CH_TXOP
    |=> cmp_txop_o == $past(conv_data_i) && cmp_bias_o == $past(bias_ff)
  ) else $error("comparison feed wrong");

  a_ack_pulse: assert property (
    ce_i && !req_i |=> !ack_o
  ) else $error("ack without request");

  a_freeze_hold: assert property (
    !ce_i |=> $stable(txop_ff) && $stable(ack_o) && $stable(por_busy_o)
  ) else $error("state moved while frozen");

  a_vin_capture: assert property (
    ce_i && conv_valid_i && conv_chan_i == DAR_CH_VIN
    |=> vin_ff == $past(conv_data_i)
  ) else $error("supply not captured");

  a_bias_capture: assert property (
    ce_i && conv_valid_i && conv_chan_i == DAR_CH_BIAS
    |=> bias_ff == $past(conv_data_i)
  ) else $error("bias not captured");

  a_txop_capture: assert property (
    ce_i && conv_valid_i && conv_chan_i == DAR_CH_TXOP
    |=> txop_ff == $past(conv_data_i)
  ) else $error("tx power not captured");

  a_temp_hold: assert property (
    !(ce_i && conv_valid_i && conv_chan_i == DAR_CH_TEMP)
    |=> $stable(temp_ff)
  ) else $error("temperature changed without conversion");

  a_bias_hold: assert property (
    !(ce_i && conv_valid_i && conv_chan_i == DAR_CH_BIAS)
    |=> $stable(bias_ff)
  ) else $error("bias changed without conversion");

  a_txop_hold: assert property (
    !(ce_i && conv_valid_i && conv_chan_i == DAR_CH_TXOP)
    |=> $stable(txop_ff)
  ) else $error("tx power changed without conversion");

  a_vin_read: assert property (
    ce_i && req_i && !we_i && slave_addr_i == DAR_SERIAL_ADDR &&
    addr_i == DAR_OFS_VIN_HI
    |=> ack_o && rdata_o == 8'($past(vin_ff))
  ) else $error("supply read wrong");

  a_bias_read: assert property (
    ce_i && req_i && !we_i && slave_addr_i == DAR_SERIAL_ADDR &&
    addr_i == DAR_OFS_BIAS_HI
    |=> ack_o && rdata_o == 8'($past(bias_ff))
  ) else $error("bias read wrong");

  a_txop_read: assert property (
    ce_i && req_i && !we_i && slave_addr_i == DAR_SERIAL_ADDR &&
    addr_i == DAR_OFS_TXOP_HI
    |=> ack_o && rdata_o == 8'($past(txop_ff))
  ) else $error("tx power read wrong");

  a_write_rdata: assert property (
    ce_i && req_i && we_i |=> $stable(rdata_o)
  ) else $error("write disturbed read data");

  a_ack_served: assert property (
    ce_i && req_i && slave_addr_i == DAR_SERIAL_ADDR |=> ack_o
  ) else $error("served request not acknowledged");

  a_seen_mark: assert property (
    ce_i && conv_valid_i |=> seen_ff[$past(conv_chan_i)]
  ) else $error("converted channel not marked");

  a_freeze_results: assert property (
    !ce_i |=> $stable(temp_ff) && $stable(vin_ff) && $stable(bias_ff) &&
    $stable(rdata_o)
  ) else $error("result moved while frozen");

endmodule
`default_nettype wire

// *** dar_host_model.sv ***
// host-side byte access model for the diagnostic result bank
`timescale 1ns/1ps
`default_nettype none
module dar_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic [6:0] slave_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    slave_o = 7'h00;
    addr_o = 8'h00;
    wdata_o = 8'hFF;
  end

  // raw pair, scaling left to the caller
  function automatic logic [15:0] raw_pair(input logic [7:0] hi, lo);
    return {hi, lo};
  endfunction

  // one byte access; released lines turn over so stale values never match
  task automatic access(input logic [6:0] sa, input logic w,
                        input logic [7:0] a, output logic got,
                        output logic [7:0] d);
    int n;
    got = 1'b0;
    d = 8'h00;
    @(negedge clk_i);
    slave_o = sa;
    we_o = w;
    addr_o = a;
    req_o = 1'b1;
    @(negedge clk_i);
    req_o = 1'b0;
    slave_o = ~sa;
    addr_o = ~a;
    for (n = 0; n < 3 && !got; n++) begin
      if (ack_i === 1'b1) begin
        got = 1'b1;
        d = rdata_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

// *** dar_result_regs_test.sv ***
// self-checking bench for the diagnostic result bank
`timescale 1ns/1ps
`default_nettype none
module dar_result_regs_test;
  import dar_pkg::*;
  logic clk_i, srst_i, ce_i, conv_valid_i, req, we, ack, por;
  logic [1:0] conv_chan_i;
  logic [6:0] sa;
  logic [7:0] conv_data_i, addr, wdata, rdata;
  wire [7:0] cmp [4];
  logic [7:0] cv [4] = '{8'h5A, 8'hC3, 8'h81, 8'hFF};
  int num_errors = 0;
  int checks_done = 0;

  dar_result_regs uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .conv_valid_i(conv_valid_i), .conv_chan_i(conv_chan_i),
    .conv_data_i(conv_data_i), .req_i(req), .we_i(we), .slave_addr_i(sa),
    .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata),
    .por_busy_o(por), .cmp_temp_o(cmp[0]), .cmp_vin_o(cmp[1]),
    .cmp_bias_o(cmp[2]), .cmp_txop_o(cmp[3]));
  dar_host_model host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata),
    .req_o(req), .we_o(we), .slave_o(sa), .addr_o(addr), .wdata_o(wdata));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic got;
    logic [7:0] d;
    host.access(DAR_SERIAL_ADDR, 1'b0, a, got, d);
    if (got !== 1'b1) begin
      num_errors++;
      $display("MISMATCH ack expected 1 seen %b", got);
      stop_test();
    end else chk($sformatf("byte %h", a), e, d);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(DAR_OFS_TEMP_HI + 8'(i), 8'h00);
    end
    chk("por", 8'h01, {7'h00, por});
  endtask

  // temperature converted last, so its byte must still read zero before
  task automatic t_conv();
    logic [15:0] p;
    for (int k = 1; k < 4; k++) begin
      @(negedge clk_i);
      conv_valid_i = 1'b1;
      conv_chan_i = 2'(k);
      conv_data_i = cv[k];
    end
    @(negedge clk_i);
    conv_valid_i = 1'b0;
    rd(DAR_OFS_TEMP_HI, 8'h00);
    chk("por", 8'h01, {7'h00, por});
    @(negedge clk_i);
    conv_valid_i = 1'b1;
    conv_chan_i = DAR_CH_TEMP;
    conv_data_i = cv[0];
    @(negedge clk_i);
    conv_valid_i = 1'b0;
    chk("por", 8'h01, {7'h00, por});
    repeat (2) @(negedge clk_i);
    chk("por", 8'h00, {7'h00, por});
    for (int i = 0; i < 4; i++) begin
      rd(DAR_OFS_TEMP_HI + 8'(2 * i), cv[i]);
      rd(DAR_OFS_TEMP_LO + 8'(2 * i), 8'h00);
      chk("cmp", cv[i], cmp[i]);
    end
    p = host.raw_pair(cmp[1], rdata);
    chk("pair hi", cv[1], p[15:8]);
    chk("pair lo", 8'h00, p[7:0]);
  endtask

  task automatic t_write();
    logic got;
    logic [7:0] d;
    host.access(DAR_SERIAL_ADDR, 1'b1, DAR_OFS_TEMP_HI, got, d);
    chk("wr ack", 8'h01, {7'h00, got});
    chk("wr rdata", 8'h00, d);
    host.access(DAR_SERIAL_ADDR, 1'b1, DAR_OFS_VIN_LO, got, d);
    rd(DAR_OFS_TEMP_HI, cv[0]);
    rd(DAR_OFS_VIN_LO, 8'h00);
    host.access(~DAR_SERIAL_ADDR, 1'b0, DAR_OFS_TEMP_HI, got, d);
    chk("foreign ack", 8'h00, {7'h00, got});
    @(negedge clk_i);
    ce_i = 1'b0;
    host.access(DAR_SERIAL_ADDR, 1'b0, DAR_OFS_VIN_HI, got, d);
    chk("frozen ack", 8'h00, {7'h00, got});
    ce_i = 1'b1;
    rd(DAR_OFS_VIN_HI, cv[1]);
  endtask

  // second reset mid-run must drop results and status back
  task automatic t_rerst();
    @(negedge clk_i);
    srst_i = 1'b1;
    @(negedge clk_i);
    srst_i = 1'b0;
    rd(DAR_OFS_TXOP_HI, 8'h00);
    chk("cmp", 8'h00, cmp[0]);
    chk("por", 8'h01, {7'h00, por});
  endtask

  initial begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    conv_valid_i = 1'b0;
    conv_chan_i = 2'h0;
    conv_data_i = 8'h00;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    t_reset();
    t_conv();
    t_write();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
